// *** design/vmp_datapath.sv ***
// Vector execution datapath: odd/even multiplies, fused negative
// multiply-subtract, NOR, OR, permute and pixel pack, one register stage.
// Assumes the register file returns operands in the cycle the specifiers
// are presented, and that decode holds the instruction for that cycle.
//
// Notes on behaviour
// - Even unsigned halfwords multiplied into four unsigned 32-bit words.
// - Odd signed bytes multiplied into eight signed 16-bit halfwords.
// - Odd signed halfwords multiplied into four signed 32-bit words.
// - Odd unsigned bytes multiplied into eight unsigned 16-bit halfwords.
// - Odd unsigned halfwords multiplied into four unsigned 32-bit words.
// - Float lanes compute minus (first times third minus second), nearest.
// - Product and difference kept exact; one rounding at the end.
// - A quiet NaN result is passed on with its sign untouched.
// - NOR writes the complement of the bitwise OR of both sources.
// - NOR of one register with itself complements it.
// - OR writes the bitwise OR of both sources.
// - OR of one register with itself copies it unchanged.
// - Permute picks bytes of the 32-byte pair by control bits 3 to 7.
// - Pixel pack turns eight source words into eight halfwords in order.
// - Halfword is word bit 7, bits 8-12, 16-20, 24-28, big-endian.
`include "vmp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module vmp_datapath
   import vmp_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic         instr_valid,
   input  wire logic [31:0]  instr,
   output logic      [4:0]   first_spec,
   output logic      [4:0]   second_spec,
   output logic      [4:0]   third_spec,
   input  wire logic [127:0] first_source_reg,
   input  wire logic [127:0] second_source_reg,
   input  wire logic [127:0] third_source_reg,
   output logic              result_valid,
   output logic      [4:0]   dest_spec,
   output logic      [127:0] dest_vector_reg,
   output logic              op_illegal,
   output logic              clamp_sticky_flag_we
);

   // ----------------------------------------
   // Fused negative multiply-subtract, one lane
   // ----------------------------------------
   // Denormals flush to signed zero: one leading-one search, no gradual underflow
   function automatic logic [31:0] vmp_nmsub(input logic [31:0] a,
                                             input logic [31:0] b,
                                             input logic [31:0] c);
      logic               za, zb, zc, ia, ib, ic, na, nb, nc;
      logic               sp, nsb, bs, ss, sr, st;
      logic [47:0]        mp;
      logic [23:0]        mb;
      logic signed [11:0] ep, eb, emax, er;
      logic [11:0]        dif;
      logic [75:0]        big, sml, s, n;
      logic [6:0]         p;
      logic [24:0]        mr;
      logic [31:0]        r;
      za  = a[`VMP_F_EXP] == `VMP_EXP_ZERO;
      zb  = b[`VMP_F_EXP] == `VMP_EXP_ZERO;
      zc  = c[`VMP_F_EXP] == `VMP_EXP_ZERO;
      ia  = a[`VMP_F_EXP] == `VMP_EXP_MAX;
      ib  = b[`VMP_F_EXP] == `VMP_EXP_MAX;
      ic  = c[`VMP_F_EXP] == `VMP_EXP_MAX;
      na  = ia & (|a[`VMP_F_FRAC]);
      nb  = ib & (|b[`VMP_F_FRAC]);
      nc  = ic & (|c[`VMP_F_FRAC]);
      sp  = a[`VMP_F_SGN] ^ c[`VMP_F_SGN];
      nsb = ~b[`VMP_F_SGN];
      // Exact 48-bit product, nothing dropped before the add
      mp  = (za | zc) ? 48'h0 : {1'b1, a[`VMP_F_FRAC]} * {1'b1, c[`VMP_F_FRAC]};
      mb  = zb ? 24'h0 : {1'b1, b[`VMP_F_FRAC]};
      ep  = $signed({4'h0, a[`VMP_F_EXP]}) + $signed({4'h0, c[`VMP_F_EXP]}) - `VMP_BIAS;
      // A zero term must never win the alignment
      ep  = (mp == 48'h0) ? -`VMP_EXP_NONE : ep;
      eb = zb ? -`VMP_EXP_NONE : $signed({4'h0, b[`VMP_F_EXP]});
      if (ep >= eb) begin
         big  = {2'h0, mp, 26'h0};
         sml  = {3'h0, mb, 49'h0};
         dif  = 12'(ep - eb);
         emax = ep;
         bs   = sp;
         ss   = nsb;
      end else begin
         big  = {3'h0, mb, 49'h0};
         sml  = {2'h0, mp, 26'h0};
         dif  = 12'(eb - ep);
         emax = eb;
         bs   = nsb;
         ss   = sp;
      end
      // Shifted-out bits fold into a sticky lsb
      if (dif >= `VMP_FRAME) begin
         st  = |sml;
         sml = '0;
      end else begin
         st  = |(sml & ~({76{1'b1}} << dif));
         sml = sml >> dif;
      end
      sml[0] = sml[0] | st;
      // Product minus second source
      if (bs == ss) begin
         s  = big + sml;
         sr = bs;
      end else if (big >= sml) begin
         s  = big - sml;
         sr = bs;
      end else begin
         s  = sml - big;
         sr = ss;
      end
      p = '0;
      for (int k = 0; k < 76; k++) begin
         if (s[k]) begin
            p = 7'(k);
         end
      end
      n  = s << (7'd75 - p);
      er = emax + $signed({5'h0, p}) - `VMP_POINT;
      // Single round to nearest even
      mr = {1'b0, n[75:52]} + {24'h0, n[51] & (n[52] | (|n[50:0]))};
      if (mr[24]) begin
         mr = mr >> 1;
         er = er + 12'sh001;
      end
      // NaN results keep their sign
      if (na) begin
         r = a | `VMP_QUIET;
      end else if (nb) begin
         r = b | `VMP_QUIET;
      end else if (nc) begin
         r = c | `VMP_QUIET;
      end else if ((ia & zc) | (za & ic) | ((ia | ic) & ib & (sp == b[`VMP_F_SGN]))) begin
         r = `VMP_QNAN;
      end else if (ia | ic) begin
         r = {~sp, `VMP_EXP_MAX, 23'h0};
      end else if (ib) begin
         r = {b[`VMP_F_SGN], `VMP_EXP_MAX, 23'h0};
      end else if (s == 76'h0) begin
         r = {~(sp & nsb), 31'h0};
      end else if (er >= `VMP_EXP_OVF) begin
         r = {~sr, `VMP_EXP_MAX, 23'h0};
      end else if (er <= 12'sh000) begin
         r = {~sr, 31'h0};
      end else begin
         r = {~sr, er[7:0], mr[22:0]};
      end
      return r;
   endfunction

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   vmp_op_t      op;
   logic [255:0] pair;
   assign first_spec  = instr[`VMP_F_SRCA];
   assign second_spec = instr[`VMP_F_SRCB];
   assign third_spec  = instr[`VMP_F_SRCC];
   assign pair        = {first_source_reg, second_source_reg};

   always_comb begin
      op = VMP_OP_NONE;
      if (instr[`VMP_F_PRIM] == `VMP_PRIMARY) begin
         if (instr[`VMP_F_VAXO] == `VMP_VA_NMSUB) begin
            op = VMP_OP_NMSUB;
         end else if (instr[`VMP_F_VAXO] == `VMP_VA_PERM) begin
            op = VMP_OP_PERM;
         end else begin
            unique case (instr[`VMP_F_XO])
               `VMP_XO_MULEUH: op = VMP_OP_MULEUH;
               `VMP_XO_MULOSB: op = VMP_OP_MULOSB;
               `VMP_XO_MULOSH: op = VMP_OP_MULOSH;
               `VMP_XO_MULOUB: op = VMP_OP_MULOUB;
               `VMP_XO_MULOUH: op = VMP_OP_MULOUH;
               `VMP_XO_NOR:    op = VMP_OP_NOR;
               `VMP_XO_OR:     op = VMP_OP_OR;
               `VMP_XO_PKPX:   op = VMP_OP_PKPX;
               default:        op = VMP_OP_NONE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Lane arithmetic
   // ----------------------------------------
   // Big-endian odd element is the low half of each wide lane
   logic [127:0] r_euh, r_osb, r_osh, r_oub, r_ouh, r_fp, r_perm, r_px;
   for (genvar h = 0; h < 8; h++) begin : g_half
      logic [31:0] word_px;
      assign r_osb[16*h +: 16] = 16'($signed(first_source_reg[16*h +: 8]) *
                                    $signed(second_source_reg[16*h +: 8]));
      assign r_oub[16*h +: 16] = first_source_reg[16*h +: 8] * second_source_reg[16*h +: 8];
      // Word h of the pair lands in halfword h
      assign word_px          = pair[32*h +: 32];
      assign r_px[16*h +: 16] = {word_px[`VMP_PX_B7], word_px[`VMP_PX_C1], word_px[`VMP_PX_C2], word_px[`VMP_PX_C3]};
   end

   for (genvar w = 0; w < 4; w++) begin : g_word
      assign r_euh[32*w +: 32] = first_source_reg[32*w+16 +: 16] * second_source_reg[32*w+16 +: 16];
      assign r_osh[32*w +: 32] = 32'($signed(first_source_reg[32*w +: 16]) *
                                    $signed(second_source_reg[32*w +: 16]));
      assign r_ouh[32*w +: 32] = first_source_reg[32*w +: 16] * second_source_reg[32*w +: 16];
      assign r_fp[32*w +: 32]  = vmp_nmsub(first_source_reg[32*w +: 32], second_source_reg[32*w +: 32],
                                           third_source_reg[32*w +: 32]);
   end

   for (genvar i = 0; i < 16; i++) begin : g_byte
      // Control bits 0 to 2 of each byte are not looked at
      assign r_perm[8*i +: 8] = pair[8*(31 - int'(third_source_reg[8*i +: 5])) +: 8];
   end

   // ----------------------------------------
   // Result register
   // ----------------------------------------
   logic         next_result_valid;
   logic         next_op_illegal;
   logic [4:0]   next_dest_spec;
   logic [127:0] next_dest_vector_reg;

   always_comb begin
      next_result_valid    = instr_valid && (op != VMP_OP_NONE);
      next_op_illegal      = instr_valid && (op == VMP_OP_NONE);
      next_dest_spec       = dest_spec;
      next_dest_vector_reg = dest_vector_reg;
      if (next_result_valid) begin
         next_dest_spec = instr[`VMP_F_DEST];
         unique case (op)
            VMP_OP_MULEUH: next_dest_vector_reg = r_euh;
            VMP_OP_MULOSB: next_dest_vector_reg = r_osb;
            VMP_OP_MULOSH: next_dest_vector_reg = r_osh;
            VMP_OP_MULOUB: next_dest_vector_reg = r_oub;
            VMP_OP_MULOUH: next_dest_vector_reg = r_ouh;
            VMP_OP_NMSUB:  next_dest_vector_reg = r_fp;
            VMP_OP_NOR:    next_dest_vector_reg = ~(first_source_reg | second_source_reg);
            VMP_OP_OR:     next_dest_vector_reg = first_source_reg | second_source_reg;
            VMP_OP_PERM:   next_dest_vector_reg = r_perm;
            VMP_OP_PKPX:   next_dest_vector_reg = r_px;
            VMP_OP_NONE:   next_dest_vector_reg = dest_vector_reg;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         result_valid    <= 1'b0;
         op_illegal      <= 1'b0;
         dest_spec       <= '0;
         dest_vector_reg <= '0;
      end else begin
         result_valid    <= next_result_valid;
         op_illegal      <= next_op_illegal;
         dest_spec       <= next_dest_spec;
         dest_vector_reg <= next_dest_vector_reg;
      end
   end

   // No saturation or status write port is ever raised
   assign clamp_sticky_flag_we = 1'b0;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   property p_decode;
      1'b1 |=> result_valid == $past(instr_valid && instr[`VMP_F_PRIM] == `VMP_PRIMARY && op != VMP_OP_NONE);
   endproperty
   a_decode: assert property (p_decode) else $error("result_valid not tied to decode");
   property p_muleuh;
      instr_valid && op == VMP_OP_MULEUH |=> result_valid &&
         dest_vector_reg[31:0] == $past(first_source_reg[31:16]) * $past(second_source_reg[31:16]);
   endproperty
   a_muleuh: assert property (p_muleuh) else $error("even unsigned halfword product wrong");
   property p_mulosb;
      instr_valid && op == VMP_OP_MULOSB |=>
         $signed(dest_vector_reg[15:0]) == $signed($past(first_source_reg[7:0])) *
                                           $signed($past(second_source_reg[7:0]));
   endproperty
   a_mulosb: assert property (p_mulosb) else $error("odd signed byte product wrong");
   property p_mulosh;
      instr_valid && op == VMP_OP_MULOSH |=>
         $signed(dest_vector_reg[127:96]) == $signed($past(first_source_reg[111:96])) *
                                             $signed($past(second_source_reg[111:96]));
   endproperty
   a_mulosh: assert property (p_mulosh) else $error("odd signed halfword product wrong");
   property p_muloub;
      instr_valid && op == VMP_OP_MULOUB |=>
         dest_vector_reg[127:112] == $past(first_source_reg[119:112]) * $past(second_source_reg[119:112]);
   endproperty
   a_muloub: assert property (p_muloub) else $error("odd unsigned byte product wrong");
   property p_mulouh;
      instr_valid && op == VMP_OP_MULOUH |=>
         dest_vector_reg[63:32] == $past(first_source_reg[47:32]) * $past(second_source_reg[47:32]);
   endproperty
   a_mulouh: assert property (p_mulouh) else $error("odd unsigned halfword product wrong");
   property p_nan;
      instr_valid && op == VMP_OP_NMSUB && first_source_reg[94:86] == 9'h1FF |=>
         dest_vector_reg[95:64] == $past(first_source_reg[95:64]);
   endproperty
   a_nan: assert property (p_nan) else $error("quiet NaN altered");
   property p_nor;
      instr_valid && op == VMP_OP_NOR |=> dest_vector_reg == ~($past(first_source_reg) | $past(second_source_reg));
   endproperty
   a_nor: assert property (p_nor) else $error("NOR result wrong");
   property p_or;
      instr_valid && op == VMP_OP_OR |=> dest_vector_reg == ($past(first_source_reg) | $past(second_source_reg));
   endproperty
   a_or: assert property (p_or) else $error("OR result wrong");
   property p_perm;
      instr_valid && op == VMP_OP_PERM && third_source_reg[124:120] == 5'h10 |=>
         dest_vector_reg[127:120] == $past(second_source_reg[127:120]);
   endproperty
   a_perm: assert property (p_perm) else $error("permute byte select wrong");
   property p_pkpx;
      instr_valid && op == VMP_OP_PKPX |=> dest_vector_reg[127:112] ==
         {$past(first_source_reg[120]), $past(first_source_reg[119:115]),
          $past(first_source_reg[111:107]), $past(first_source_reg[103:99])};
   endproperty
   a_pkpx: assert property (p_pkpx) else $error("pixel pack wrong");
   c_fp:    cover property (instr_valid && op == VMP_OP_NMSUB ##1 result_valid);
   c_perm:  cover property (instr_valid && op == VMP_OP_PERM ##1 instr_valid && op == VMP_OP_PKPX);
   c_alias: cover property (instr_valid && op == VMP_OP_OR && first_spec == second_spec);
   c_bad:   cover property (op_illegal);

endmodule

`default_nettype wire

// *** shared/vmp_cfg.svh ***
// Constants for the vector multiply, logic, permute and pack datapath.
// Assumes the 32-bit instruction word is indexed with bit 31 as the
// most significant bit (big-endian bit 0).
`ifndef VMP_CFG_SVH
`define VMP_CFG_SVH
// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define VMP_PRIMARY     6'h04
`define VMP_F_PRIM      31:26
`define VMP_F_DEST      25:21
`define VMP_F_SRCA      20:16
`define VMP_F_SRCB      15:11
`define VMP_F_SRCC      10:6
`define VMP_F_XO        10:0
`define VMP_F_VAXO      5:0
`define VMP_XO_MULEUH   11'h248
`define VMP_XO_MULOSB   11'h108
`define VMP_XO_MULOSH   11'h148
`define VMP_XO_MULOUB   11'h008
`define VMP_XO_MULOUH   11'h048
`define VMP_XO_NOR      11'h504
`define VMP_XO_OR       11'h484
`define VMP_XO_PKPX     11'h30E
`define VMP_VA_NMSUB    6'h2F
`define VMP_VA_PERM     6'h2B
// ----------------------------------------
// Single-precision fields and constants
// ----------------------------------------
`define VMP_F_SGN       31
`define VMP_F_EXP       30:23
`define VMP_F_FRAC      22:0
`define VMP_EXP_MAX     8'hFF
`define VMP_EXP_ZERO    8'h00
`define VMP_QUIET       32'h00400000
`define VMP_QNAN        32'h7FC00000
`define VMP_BIAS        12'sh07F
`define VMP_EXP_NONE    12'sh190
`define VMP_EXP_OVF     12'sh0FF
`define VMP_POINT       12'sh048
`define VMP_FRAME       12'h04C
// ----------------------------------------
// Permute and pixel fields
// ----------------------------------------
`define VMP_PERM_IDX    4:0
`define VMP_PX_B7       24
`define VMP_PX_C1       23:19
`define VMP_PX_C2       15:11
`define VMP_PX_C3       7:3
`endif

// *** shared/vmp_pkg.sv ***
// Types for the vector multiply, logic, permute and pack datapath.
// Assumes vmp_cfg.svh is on the include path.
package vmp_pkg;
   typedef enum logic [3:0] {
      VMP_OP_NONE,
      VMP_OP_MULEUH,
      VMP_OP_MULOSB,
      VMP_OP_MULOSH,
      VMP_OP_MULOUB,
      VMP_OP_MULOUH,
      VMP_OP_NMSUB,
      VMP_OP_NOR,
      VMP_OP_OR,
      VMP_OP_PERM,
      VMP_OP_PKPX
   } vmp_op_t;
endpackage

// *** testbench/vmp_regfile_model.sv ***
// Behavioural vector register file standing on the far side of the datapath.
// Assumes specifiers arrive combinationally and results are written back at
// the clock edge where result_valid is high.
`timescale 1ns/10ps
`default_nettype none

module vmp_regfile_model (
   input  wire logic         mclk,
   input  wire logic         instr_valid,
   input  wire logic [4:0]   first_spec,
   input  wire logic [4:0]   second_spec,
   input  wire logic [4:0]   third_spec,
   output logic      [127:0] first_source_reg,
   output logic      [127:0] second_source_reg,
   output logic      [127:0] third_source_reg,
   input  wire logic         result_valid,
   input  wire logic [4:0]   dest_spec,
   input  wire logic [127:0] dest_vector_reg,
   input  wire logic         load_en,
   input  wire logic [4:0]   load_idx,
   input  wire logic [127:0] load_data
);
   logic [127:0] regs [0:31];

   // ----------------------------------------
   // Read ports
   // ----------------------------------------
   // Outside an instruction the operand lines show the inverse, so a stale
   // value can never be mistaken for a live one
   always_comb begin
      first_source_reg  = instr_valid ? regs[first_spec]  : ~regs[first_spec];
      second_source_reg = instr_valid ? regs[second_spec] : ~regs[second_spec];
      third_source_reg  = instr_valid ? regs[third_spec]  : ~regs[third_spec];
   end

   // ----------------------------------------
   // Write port
   // ----------------------------------------
   always @(posedge mclk) begin
      if (load_en) begin
         regs[load_idx] <= load_data;
      end else if (result_valid) begin
         regs[dest_spec] <= dest_vector_reg;
      end
   end
endmodule

`default_nettype wire

// *** testbench/vmp_datapath_tb_top.sv ***
// Self-checking bench for the vector datapath with a register file model.
// Assumes a one-cycle result latency and back-to-back issue.
`timescale 1ns/10ps
`default_nettype none
`include "vmp_cfg.svh"

module vmp_datapath_tb_top
   import vmp_pkg::*;
;
   logic         mclk;
   logic         reset_n;
   logic         instr_valid;
   logic [31:0]  instr;
   logic [4:0]   first_spec;
   logic [4:0]   second_spec;
   logic [4:0]   third_spec;
   logic [127:0] first_source_reg;
   logic [127:0] second_source_reg;
   logic [127:0] third_source_reg;
   logic         result_valid;
   logic [4:0]   dest_spec;
   logic [127:0] dest_vector_reg;
   logic         op_illegal;
   logic         clamp_sticky_flag_we;
   logic         load_en;
   logic [4:0]   load_idx;
   logic [127:0] load_data;
   logic [127:0] tv [1:6];
   int           errors;
   int           n_checks;

   vmp_datapath u_dut (.mclk(mclk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
      .first_spec(first_spec), .second_spec(second_spec), .third_spec(third_spec),
      .first_source_reg(first_source_reg), .second_source_reg(second_source_reg),
      .third_source_reg(third_source_reg), .result_valid(result_valid), .dest_spec(dest_spec),
      .dest_vector_reg(dest_vector_reg), .op_illegal(op_illegal),
      .clamp_sticky_flag_we(clamp_sticky_flag_we));

   vmp_regfile_model u_model (.mclk(mclk), .instr_valid(instr_valid), .first_spec(first_spec),
      .second_spec(second_spec), .third_spec(third_spec), .first_source_reg(first_source_reg),
      .second_source_reg(second_source_reg), .third_source_reg(third_source_reg),
      .result_valid(result_valid), .dest_spec(dest_spec), .dest_vector_reg(dest_vector_reg),
      .load_en(load_en), .load_idx(load_idx), .load_data(load_data));

   always #5 mclk = ~mclk;

   // ----------------------------------------
   // Reference models
   // ----------------------------------------
   function automatic logic [127:0] mul_ref(input logic [127:0] a, input logic [127:0] b,
                                            input int w, input bit odd, input bit sg);
      logic [127:0] r;
      longint       x;
      longint       y;
      int           sh;
      r = '0;
      for (int k = 0; k < 64 / w; k++) begin
         sh = 128 - 2 * w * (k + 1) + (odd ? 0 : w);
         x = longint'((a >> sh) & ((128'h1 << w) - 1));
         y = longint'((b >> sh) & ((128'h1 << w) - 1));
         if (sg && x >= (longint'(1) << (w - 1))) x -= longint'(1) << w;
         if (sg && y >= (longint'(1) << (w - 1))) y -= longint'(1) << w;
         r |= (128'(x * y) & ((128'h1 << (2 * w)) - 1)) << (128 - 2 * w * (k + 1));
      end
      return r;
   endfunction

   function automatic logic [127:0] perm_ref(input logic [255:0] src, input logic [127:0] c);
      logic [127:0] r;
      int           idx;
      for (int i = 0; i < 16; i++) begin
         idx = int'(c[124 - 8 * i -: 5]);
         r[127 - 8 * i -: 8] = src[255 - 8 * idx -: 8];
      end
      return r;
   endfunction

   function automatic logic [127:0] pkpx_ref(input logic [255:0] src);
      logic [127:0] r;
      logic [31:0]  w;
      for (int i = 0; i < 8; i++) begin
         w = src[255 - 32 * i -: 32];
         r[127 - 16 * i -: 16] = {w[24], w[23:19], w[15:11], w[7:3]};
      end
      return r;
   endfunction

   function automatic logic [31:0] vx(input logic [4:0] d, input logic [4:0] a, input logic [4:0] b,
                                      input logic [10:0] xo);
      return {6'h04, d, a, b, xo};
   endfunction

   // ----------------------------------------
   // Checking and driving
   // ----------------------------------------
   task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Called at a falling edge; leaves the instruction up so the next call issues back to back
   task automatic exec(input logic [31:0] word, input logic [127:0] exp);
      instr = word;
      instr_valid = 1'b1;
      @(negedge mclk);
      chk("result_valid", 128'h1, 128'(result_valid));
      chk("op_illegal", 128'h0, 128'(op_illegal));
      chk("dest_spec", 128'(word[25:21]), 128'(dest_spec));
      chk("dest_vector_reg", exp, dest_vector_reg);
      chk("clamp_sticky_flag_we", 128'h0, 128'(clamp_sticky_flag_we));
   endtask

   task automatic go_idle();
      instr_valid = 1'b0;
      @(negedge mclk);
      chk("result_valid idle", 128'h0, 128'(result_valid));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_load();
      for (int i = 1; i <= 6; i++) begin
         load_en = 1'b1;
         load_idx = 5'(i);
         load_data = tv[i];
         @(negedge mclk);
      end
      load_en = 1'b0;
   endtask

   task automatic t_ops();
      exec(vx(5'h07, 5'h01, 5'h02, `VMP_XO_MULEUH), mul_ref(tv[1], tv[2], 16, 0, 0));
      exec(vx(5'h08, 5'h01, 5'h02, `VMP_XO_MULOSB), mul_ref(tv[1], tv[2], 8, 1, 1));
      exec(vx(5'h09, 5'h01, 5'h02, `VMP_XO_MULOSH), mul_ref(tv[1], tv[2], 16, 1, 1));
      exec(vx(5'h0A, 5'h01, 5'h02, `VMP_XO_MULOUB), mul_ref(tv[1], tv[2], 8, 1, 0));
      exec(vx(5'h0B, 5'h01, 5'h02, `VMP_XO_MULOUH), mul_ref(tv[1], tv[2], 16, 1, 0));
      exec(vx(5'h0C, 5'h01, 5'h02, `VMP_XO_NOR), ~(tv[1] | tv[2]));
      exec(vx(5'h0D, 5'h03, 5'h03, `VMP_XO_NOR), ~tv[3]);
      exec(vx(5'h0E, 5'h01, 5'h02, `VMP_XO_OR), tv[1] | tv[2]);
      exec(vx(5'h0F, 5'h01, 5'h01, `VMP_XO_OR), tv[1]);
      exec({6'h04, 5'h10, 5'h01, 5'h02, 5'h03, `VMP_VA_PERM}, perm_ref({tv[1], tv[2]}, tv[3]));
      exec(vx(5'h11, 5'h01, 5'h02, `VMP_XO_PKPX), pkpx_ref({tv[1], tv[2]}));
      // Lanes: plain, negative quiet NaN, cancellation below single rounding, exact zero
      exec({6'h04, 5'h12, 5'h04, 5'h05, 5'h06, `VMP_VA_NMSUB},
           128'hC0A00000_FFC00001_A8800000_80000000);
      go_idle();
   endtask

   task automatic t_illegal();
      instr = {6'h05, 5'h13, 5'h01, 5'h02, `VMP_XO_OR};
      instr_valid = 1'b1;
      @(negedge mclk);
      chk("op_illegal", 128'h1, 128'(op_illegal));
      chk("result_valid", 128'h0, 128'(result_valid));
      instr = vx(5'h14, 5'h01, 5'h02, 11'h7FF);
      @(negedge mclk);
      chk("op_illegal", 128'h1, 128'(op_illegal));
      chk("dest_spec", 128'h12, 128'(dest_spec));
      chk("dest_vector_reg", 128'hC0A00000_FFC00001_A8800000_80000000, dest_vector_reg);
      instr_valid = 1'b0;
      @(negedge mclk);
      chk("op_illegal idle", 128'h0, 128'(op_illegal));
   endtask

   task automatic t_reset_mid();
      instr = vx(5'h15, 5'h01, 5'h02, `VMP_XO_OR);
      instr_valid = 1'b1;
      reset_n = 1'b0;
      @(negedge mclk);
      chk("result_valid in reset", 128'h0, 128'(result_valid));
      chk("dest_vector_reg in reset", 128'h0, dest_vector_reg);
      chk("dest_spec in reset", 128'h0, 128'(dest_spec));
      reset_n = 1'b1;
      exec(vx(5'h15, 5'h02, 5'h01, `VMP_XO_OR), tv[1] | tv[2]);
      go_idle();
   endtask

   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      load_en = 1'b0;
      load_idx = '0;
      load_data = '0;
      errors = 0;
      n_checks = 0;
      tv[1] = 128'hFF807F01_80007FFF_1234ABCD_0001FFFF;
      tv[2] = 128'h80FF7F80_FFFF8000_56789ABC_FFFE0002;
      tv[3] = 128'hF0141810_1615191A_3C1C1C13_081DFB0E;
      tv[4] = 128'h40000000_FFC00001_3F800001_3F800000;
      tv[5] = 128'h3F800000_3F800000_3F800002_3F800000;
      tv[6] = 128'h40400000_40400000_3F800001_3F800000;
      repeat (4) @(negedge mclk);
      chk("dest_vector_reg at reset", 128'h0, dest_vector_reg);
      chk("result_valid at reset", 128'h0, 128'(result_valid));
      reset_n = 1'b1;
      t_load();
      t_ops();
      t_illegal();
      t_reset_mid();
      complete_run();
   end

   // Whole run needs well under a hundred cycles
   initial begin
      #10000;
      errors++;
      complete_run();
   end
endmodule

`default_nettype wire
